// ---- logic/sac_top.sv ----
// Overview of operation
// - Nine-way input selector: eight external pins plus temperature sensor.
// - Each adjacent external pair is two single-ended or one differential.
// - Start from software, timer 2 overflow, timer 3 overflow or pin.
// - Finished conversion raises interrupt request and sets pollable flag.
// - Each 10-bit result is captured into high and low byte registers.
// - Result is placed right- or left-aligned by a software setting.
// - Window interrupt when the result lies inside programmed bounds.
// - Background mode converts silently, interrupting only inside window.
// - Software shutdown disables converter; no conversion starts then.
// - Sequencer sustains back-to-back conversions up to 100 ksps.
// - Software selects on-chip or external voltage reference.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
module sac_top import sac_pkg::*; #(
  parameter int unsigned AW = 8
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write address
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]    s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  // AXI4-Lite write response
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  output logic [1:0]         s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic [2:0]    s_axi_arprot,
  // AXI4-Lite read data
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  // Start triggers
  input  wire logic          tmr2_ovf,
  input  wire logic          tmr3_ovf,
  input  wire logic          ext_start,
  // Analog core
  input  wire logic          cmp_out,
  output logic               adc_enable,
  output logic               ref_ext_sel,
  output logic [3:0]         mux_sel,
  output logic               mux_diff,
  output logic               track,
  output logic [RES_W-1:0]   dac_code,
  // Interrupt requests
  output logic               eoc_irq,
  output logic               win_irq
);
  typedef struct packed {
    // Bus slave
    logic              awrdy;
    logic              aw_have;
    logic [AW-1:0]     awaddr;
    logic              wrdy;
    logic              w_have;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    // Configuration
    logic              en;
    sac_trig_t         trig;
    logic              ljust;
    logic              refext;
    logic              bgmon;
    logic [3:0]        chsel;
    logic [3:0]        diff;
    logic [RES_W-1:0]  win_lo;
    logic [RES_W-1:0]  win_hi;
    // Status and results
    logic              busy;
    logic              eoc;
    logic              win;
    logic [7:0]        res_hi;
    logic [7:0]        res_lo;
    // Pin synchronisers
    logic              ext_s1;
    logic              ext_s2;
    logic              ext_prev;
    logic              cmp_s1;
    logic              cmp_s2;
    // Core control
    logic [3:0]        mux;
    logic              mdiff;
    logic              start;
    logic              irq_eoc;
    logic              irq_win;
  } sac_s_t;

  sac_s_t           q;
  sac_s_t           d;
  logic             tick;
  logic             sar_busy;
  logic             sar_sample;
  logic             sar_done;
  logic [RES_W-1:0] sar_dac;
  logic [RES_W-1:0] sar_res;

  // Slot pacing restarts with each conversion for fixed latency
  sac_clkdiv #(
    .DIV (SLOT_CYCLES)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clr     (q.start),
    .tick    (tick)
  );

  sac_sar #(
    .W     (RES_W),
    .TRACK (TRACK_SLOTS)
  ) u_sar (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (q.start),
    .tick    (tick),
    .cmp_in  (q.cmp_s2),
    .busy    (sar_busy),
    .sample  (sar_sample),
    .done    (sar_done),
    .dac     (sar_dac),
    .result  (sar_res)
  );

  logic wr_go;
  logic acc_ok;
  logic sw_start;
  logic trig_hit;
  logic in_win;
  logic eoc_clr;
  logic win_clr;
  logic [AW-1:0] ra;
  logic [31:0]   rd;
  logic          rd_ok;
  logic          wr_ok;
  logic [15:0]   wmask;

  always_comb begin
    d        = q;
    sw_start = 1'b0;
    eoc_clr  = 1'b0;
    win_clr  = 1'b0;
    wr_ok    = 1'b1;
    rd_ok    = 1'b1;
    rd       = '0;
    ra       = s_axi_araddr;
    wmask    = {{8{q.wstrb[1]}}, {8{q.wstrb[0]}}};

    // Pins cross two flops before any logic looks at them
    d.ext_s1   = ext_start;
    d.ext_s2   = q.ext_s1;
    d.ext_prev = q.ext_s2;
    d.cmp_s1   = cmp_out;
    d.cmp_s2   = q.cmp_s1;

    // Address and data are taken in either order
    if (s_axi_awvalid && q.awrdy) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wrdy) begin
      d.w_have = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    wr_go = q.aw_have && q.w_have && !q.bvalid;
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      case (q.awaddr)
        OFS_CTRL: begin
          if (q.wstrb[0]) begin
            d.en     = q.wdata[CTRL_EN_BIT];
            d.trig   = sac_trig_t'(q.wdata[CTRL_TRIG_LSB +: 2]);
            sw_start = q.wdata[CTRL_SWSTART_BIT];
            d.ljust  = q.wdata[CTRL_LJUST_BIT];
            d.refext = q.wdata[CTRL_REFEXT_BIT];
            d.bgmon  = q.wdata[CTRL_BGMON_BIT];
          end
        end
        OFS_CHAN: begin
          if (q.wstrb[0]) begin
            d.chsel = q.wdata[CHAN_SEL_LSB +: 4];
            d.diff  = q.wdata[CHAN_DIFF_LSB +: 4];
          end
        end
        OFS_STAT: begin
          if (q.wstrb[0]) begin
            eoc_clr = q.wdata[STAT_EOC_BIT];
            win_clr = q.wdata[STAT_WIN_BIT];
          end
        end
        OFS_WIN_LO: begin
          d.win_lo = RES_W'((16'(q.win_lo) & ~wmask)
                            | (q.wdata[15:0] & wmask));
        end
        OFS_WIN_HI: begin
          d.win_hi = RES_W'((16'(q.win_hi) & ~wmask)
                            | (q.wdata[15:0] & wmask));
        end
        OFS_RES_HI, OFS_RES_LO: begin
          wr_ok = 1'b1;
        end
        default: begin
          wr_ok = 1'b0;
        end
      endcase
      d.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    d.awrdy = !d.aw_have && !d.bvalid;
    d.wrdy  = !d.w_have && !d.bvalid;

    // Read side: one outstanding read, data registered with valid
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    case (ra)
      OFS_CTRL: begin
        rd[CTRL_EN_BIT]         = q.en;
        rd[CTRL_TRIG_LSB +: 2]  = q.trig;
        rd[CTRL_LJUST_BIT]      = q.ljust;
        rd[CTRL_REFEXT_BIT]     = q.refext;
        rd[CTRL_BGMON_BIT]      = q.bgmon;
      end
      OFS_CHAN: begin
        rd[CHAN_SEL_LSB +: 4]   = q.chsel;
        rd[CHAN_DIFF_LSB +: 4]  = q.diff;
      end
      OFS_STAT: begin
        rd[STAT_BUSY_BIT]       = q.busy;
        rd[STAT_EOC_BIT]        = q.eoc;
        rd[STAT_WIN_BIT]        = q.win;
      end
      OFS_RES_HI: rd[7:0]       = q.res_hi;
      OFS_RES_LO: rd[7:0]       = q.res_lo;
      OFS_WIN_LO: rd[RES_W-1:0] = q.win_lo;
      OFS_WIN_HI: rd[RES_W-1:0] = q.win_hi;
      default: rd_ok = 1'b0;
    endcase
    if (s_axi_arvalid && q.arrdy) begin
      d.rvalid = 1'b1;
      d.rdata  = rd;
      d.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    d.arrdy = !d.rvalid;

    // Trigger source selection
    case (q.trig)
      TRIG_SW:   trig_hit = sw_start;
      TRIG_TMR2: trig_hit = tmr2_ovf;
      TRIG_TMR3: trig_hit = tmr3_ovf;
      TRIG_EXT:  trig_hit = q.ext_s2 && !q.ext_prev;
      default:   trig_hit = 1'b0;
    endcase

    // Shutdown and busy both swallow triggers
    d.start = 1'b0;
    // Core state checked too, so a late result never meets a new start
    acc_ok  = d.en && !q.busy && !sar_busy;
    if (trig_hit && acc_ok) begin
      d.start = 1'b1;
      d.busy  = 1'b1;
      // Channel is frozen for the whole conversion
      if (q.chsel >= CH_TEMP) begin
        d.mux   = CH_TEMP;
        d.mdiff = 1'b0;
      end else if (q.diff[q.chsel[2:1]]) begin
        d.mux   = {q.chsel[3:1], 1'b0};
        d.mdiff = 1'b1;
      end else begin
        d.mux   = q.chsel;
        d.mdiff = 1'b0;
      end
    end

    in_win = (sar_res >= q.win_lo) && (sar_res <= q.win_hi);
    if (sar_done) begin
      d.busy = 1'b0;
      if (q.ljust) begin
        d.res_hi = sar_res[9:2];
        d.res_lo = {sar_res[1:0], 6'h00};
      end else begin
        d.res_hi = {6'h00, sar_res[9:8]};
        d.res_lo = sar_res[7:0];
      end
    end

    // Hardware set beats a same-cycle software clear
    d.eoc = (q.eoc && !eoc_clr) || sar_done;
    d.win = (q.win && !win_clr) || (sar_done && in_win);
    d.irq_eoc = d.eoc && !q.bgmon;
    d.irq_win = d.win;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q        <= '0;
      q.en     <= CTRL_RST[CTRL_EN_BIT];
      q.chsel  <= CHAN_RST[CHAN_SEL_LSB +: 4];
      q.diff   <= CHAN_RST[CHAN_DIFF_LSB +: 4];
      q.win_lo <= WIN_LO_RST;
      q.win_hi <= WIN_HI_RST;
    end else begin
      q <= d;
    end
  end

  // A 350-cycle conversion leaves margin within the 400-cycle budget
  assign track         = sar_sample;
  assign dac_code      = sar_dac;
  assign adc_enable    = q.en;
  assign ref_ext_sel   = q.refext;
  assign mux_sel       = q.mux;
  assign mux_diff      = q.mdiff;
  assign eoc_irq       = q.irq_eoc;
  assign win_irq       = q.irq_win;
  assign s_axi_awready = q.awrdy;
  assign s_axi_wready  = q.wrdy;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arrdy;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
endmodule

// ---- logic/sac_pkg.sv ----
package sac_pkg;
  // System clock and the throughput that the sequencer must sustain
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned MAX_RATE_SPS = 100_000;
  localparam int unsigned CONV_CYCLES  = CLK_HZ / MAX_RATE_SPS;
  // A conversion is paced in slots: tracking slots, then one per bit
  localparam int unsigned SAR_SLOTS    = 16;
  localparam int unsigned SLOT_CYCLES  = CONV_CYCLES / SAR_SLOTS;
  localparam int unsigned TRACK_SLOTS  = 4;
  localparam int unsigned RES_W        = 10;
  localparam int unsigned N_EXT        = 8;
  localparam logic [3:0]  CH_TEMP      = 4'h8;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CHAN   = 8'h04;
  localparam logic [7:0] OFS_STAT   = 8'h08;
  localparam logic [7:0] OFS_RES_HI = 8'h0c;
  localparam logic [7:0] OFS_RES_LO = 8'h10;
  localparam logic [7:0] OFS_WIN_LO = 8'h14;
  localparam logic [7:0] OFS_WIN_HI = 8'h18;

  // Control fields
  localparam int unsigned CTRL_EN_BIT      = 0;
  localparam int unsigned CTRL_TRIG_LSB    = 1;
  localparam int unsigned CTRL_SWSTART_BIT = 3;
  localparam int unsigned CTRL_LJUST_BIT   = 4;
  localparam int unsigned CTRL_REFEXT_BIT  = 5;
  localparam int unsigned CTRL_BGMON_BIT   = 6;
  // Channel fields
  localparam int unsigned CHAN_SEL_LSB     = 0;
  localparam int unsigned CHAN_DIFF_LSB    = 4;
  // Status fields
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_EOC_BIT     = 1;
  localparam int unsigned STAT_WIN_BIT     = 2;

  // Reset values
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CHAN_RST   = 8'h00;
  localparam logic [9:0]  WIN_LO_RST = 10'h000;
  localparam logic [9:0]  WIN_HI_RST = 10'h3ff;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TRIG_SW,
    TRIG_TMR2,
    TRIG_TMR3,
    TRIG_EXT
  } sac_trig_t;
endpackage

// ---- logic/sac_clkdiv.sv ----
module sac_clkdiv import sac_pkg::*; #(
  parameter int unsigned DIV = SLOT_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Restart the count so ticks align to a conversion start
  input  wire logic clr,
  output logic      tick
);
  localparam int unsigned CW = $clog2(DIV);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } sac_div_t;

  sac_div_t q;
  sac_div_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (clr) begin
      d.cnt = '0;
    end else if (q.cnt == CW'(DIV - 1)) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + CW'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;
endmodule

// ---- logic/sac_sar.sv ----
module sac_sar import sac_pkg::*; #(
  parameter int unsigned W     = RES_W,
  parameter int unsigned TRACK = TRACK_SLOTS
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Sequencing
  input  wire logic         start,
  input  wire logic         tick,
  input  wire logic         cmp_in,
  output logic              busy,
  output logic              sample,
  output logic              done,
  // Trial code and result
  output logic [W-1:0]      dac,
  output logic [W-1:0]      result
);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONV
  } sac_sar_st_t;

  typedef struct packed {
    sac_sar_st_t st;
    logic [3:0]  cnt;
    logic [W-1:0] code;
    logic [W-1:0] res;
    logic        done;
    logic        samp;
  } sac_sar_s_t;

  sac_sar_s_t q;
  sac_sar_s_t d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (start) begin
          d.st   = ST_TRACK;
          d.cnt  = '0;
          d.code = '0;
        end
      end
      ST_TRACK: begin
        if (tick) begin
          if (q.cnt == 4'(TRACK - 1)) begin
            d.st   = ST_CONV;
            d.cnt  = 4'(W - 1);
            d.code = W'(1) << (W - 1);
          end else begin
            d.cnt = q.cnt + 4'h1;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          // Comparator high means input is at or above the trial code
          if (!cmp_in) begin
            d.code = q.code & ~(W'(1) << q.cnt);
          end
          if (q.cnt == 4'h0) begin
            d.st   = ST_IDLE;
            d.res  = d.code;
            d.done = 1'b1;
          end else begin
            d.code = d.code | (W'(1) << (q.cnt - 4'h1));
            d.cnt  = q.cnt - 4'h1;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // Kept in a flop so the track pin has no decode glitches
    d.samp = (d.st == ST_TRACK);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy   = (q.st != ST_IDLE);
  assign sample = q.samp;
  assign done   = q.done;
  assign dac    = q.code;
  assign result = q.res;
endmodule

// ---- sim/sac_top_asserts.sv ----
module sac_top_chk import sac_pkg::*; (
  // Clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // Register bus handshakes
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  // Converter side
  input wire logic       adc_enable,
  input wire logic [3:0] mux_sel,
  input wire logic       mux_diff,
  input wire logic       track,
  input wire logic       eoc_irq,
  input wire logic       win_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  // Tracking length, and cycles since tracking ended (saturating)
  logic [9:0] trk_q;
  logic [9:0] age_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trk_q <= 10'h000;
      age_q <= 10'h000;
    end else begin
      trk_q <= track ? trk_q + 10'h001 : 10'h000;
      if (track) age_q <= 10'h000;
      else if (age_q != 10'h3ff) age_q <= age_q + 10'h001;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_trk_len; $fell(track) |-> trk_q inside {[10'h063:10'h065]};
  endproperty
  a_trk_len: assert property (p_trk_len) else $error("track length");
  property p_rest; $fell(track) |=> !track [*8]; endproperty
  a_rest: assert property (p_rest) else $error("early restart");
  property p_eoc_t; $rose(eoc_irq) |-> age_q inside {[10'h0f5:10'h104]};
  endproperty
  a_eoc_t: assert property (p_eoc_t) else $error("eoc timing");
  property p_win_t; $rose(win_irq) |-> age_q inside {[10'h0f5:10'h104]};
  endproperty
  a_win_t: assert property (p_win_t) else $error("window timing");
  property p_shut; $rose(track) |-> $past(adc_enable); endproperty
  a_shut: assert property (p_shut) else $error("start in shutdown");
  property p_mux; mux_sel <= CH_TEMP; endproperty
  a_mux: assert property (p_mux) else $error("channel range");
  property p_diff; mux_diff |-> !mux_sel[0] && mux_sel < CH_TEMP; endproperty
  a_diff: assert property (p_diff) else $error("pair select");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  property p_wblk; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_wblk: assert property (p_wblk) else $error("awready with bvalid");

  c_win: cover property ($rose(win_irq));
  c_eoc: cover property ($rose(eoc_irq));
  c_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind sac_top sac_top_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .adc_enable(adc_enable), .mux_sel(mux_sel),
  .mux_diff(mux_diff), .track(track), .eoc_irq(eoc_irq), .win_irq(win_irq)
);

// ---- sim/test_sac_top.sv ----
module test_sac_top import sac_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_rready = 1'b0, tmr2_ovf = 1'b0, tmr3_ovf = 1'b0;
  logic        ext_start = 1'b0, cmp_out = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ctl;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, adc_enable, ref_ext_sel, mux_diff, track;
  logic        eoc_irq, win_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [3:0]  mux_sel;
  logic [9:0]  dac_code, vin = 10'h000;
  int          error_cnt = 0, n_compared = 0, cyc = 0, t0;

  sac_top DUT (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tmr2_ovf,
    .tmr3_ovf, .ext_start, .cmp_out, .adc_enable, .ref_ext_sel, .mux_sel,
    .mux_diff, .track, .dac_code, .eoc_irq, .win_irq
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // Ideal comparator, so a correct search returns vin exactly
  always @(posedge aclk) begin
    cmp_out <= (vin >= dac_code);
    cyc <= cyc + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Response is accepted late on purpose, so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(rdat, exp);
  endtask
  task automatic fire(input sac_trig_t tg);
    case (tg)
      TRIG_SW:   wr(OFS_CTRL, {24'h0, ctl | 8'h08});
      TRIG_TMR2: tmr2_ovf <= 1'b1;
      TRIG_TMR3: tmr3_ovf <= 1'b1;
      default:   ext_start <= 1'b1;
    endcase
    @(posedge aclk);
    tmr2_ovf <= 1'b0;
    tmr3_ovf <= 1'b0;
    repeat (4) @(posedge aclk);
    ext_start <= 1'b0;
  endtask
  task automatic conv(input sac_trig_t tg, input logic [9:0] v, input bit dbl);
    int n;
    vin <= v;
    t0 = cyc;
    fire(tg);
    rd(OFS_STAT);
    chk({31'h0, rdat[STAT_BUSY_BIT]}, 32'h1);
    if (dbl) fire(tg);
    n = 0;
    while (rdat[STAT_BUSY_BIT] !== 1'b0 && n < 200) begin
      rd(OFS_STAT);
      n++;
    end
    chk({31'h0, (cyc - t0) <= CONV_CYCLES}, 32'h1);
  endtask
  task automatic post(input logic [9:0] v, input bit lj,
                      input logic [31:0] st, input bit ei, input bit wi);
    logic [31:0] hi;
    logic [31:0] lo;
    hi = lj ? {24'h0, v[9:2]} : {30'h0, v[9:8]};
    lo = lj ? {24'h0, v[1:0], 6'h00} : {24'h0, v[7:0]};
    rdc(OFS_RES_HI, hi);
    rdc(OFS_RES_LO, lo);
    rdc(OFS_STAT, st);
    chk({30'h0, eoc_irq, win_irq}, {30'h0, ei, wi});
    wr(OFS_STAT, 32'h6);
    rdc(OFS_STAT, 32'h0);
  endtask

  task automatic t_reset;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_CHAN, 32'h0);
    rdc(OFS_WIN_LO, 32'h0);
    rdc(OFS_WIN_HI, 32'h3ff);
    rdc(8'h1c, 32'h0);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(8'h1c, 32'h1);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFS_RES_HI, 32'hff);
    rdc(OFS_RES_HI, 32'h0);
    chk({31'h0, adc_enable}, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_shut;
    wr(OFS_CTRL, 32'h08);
    repeat (10) @(posedge aclk);
    rdc(OFS_STAT, 32'h0);
    chk({31'h0, track}, 32'h0);
    wr(OFS_CTRL, 32'h21);
    chk({30'h0, adc_enable, ref_ext_sel}, 32'h3);
    wr(OFS_CTRL, 32'h01);
    chk({30'h0, adc_enable, ref_ext_sel}, 32'h2);
    $display("shutdown test done");
  endtask
  task automatic t_trig;
    logic [9:0] v;
    logic [3:0] m;
    logic       d;
    for (int ch = 0; ch < 9; ch++) begin
      v = (ch == 8) ? 10'h3ff : 10'(ch * 10'h07b);
      ctl = {3'h0, ch[2], 1'b0, 2'(ch % 4), 1'b1};
      d = (ch < 8) && ch[1];
      m = d ? (4'(ch) & 4'he) : 4'(ch);
      wr(OFS_CTRL, {24'h0, ctl});
      wr(OFS_CHAN, {24'h0, 4'ha, 4'(ch)});
      conv(sac_trig_t'(ch % 4), v, 1'b0);
      chk({27'h0, mux_diff, mux_sel}, {27'h0, d, m});
      post(v, ch[2], 32'h6, 1'b1, 1'b1);
    end
    $display("trigger test done");
  endtask
  task automatic t_busy;
    ctl = 8'h05;
    wr(OFS_CTRL, 32'h05);
    fire(TRIG_TMR2);
    rdc(OFS_STAT, 32'h0);
    conv(TRIG_TMR3, 10'h155, 1'b1);
    repeat (20) @(posedge aclk);
    post(10'h155, 1'b0, 32'h6, 1'b1, 1'b1);
    $display("busy test done");
  endtask
  task automatic t_win;
    wr(OFS_WIN_LO, 32'h100);
    wr(OFS_WIN_HI, 32'h200);
    ctl = 8'h41;
    wr(OFS_CTRL, 32'h41);
    conv(TRIG_SW, 10'h100, 1'b0);
    post(10'h100, 1'b0, 32'h6, 1'b0, 1'b1);
    conv(TRIG_SW, 10'h201, 1'b0);
    post(10'h201, 1'b0, 32'h2, 1'b0, 1'b0);
    ctl = 8'h01;
    wr(OFS_CTRL, 32'h01);
    conv(TRIG_SW, 10'h200, 1'b0);
    post(10'h200, 1'b0, 32'h6, 1'b1, 1'b1);
    conv(TRIG_SW, 10'h0ff, 1'b0);
    post(10'h0ff, 1'b0, 32'h2, 1'b1, 1'b0);
    $display("window test done");
  endtask

  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_shut();
    t_trig();
    t_busy();
    t_win();
    end_of_test();
  end
  // Whole run needs about 5500 cycles
  initial begin
    repeat (30000) @(posedge aclk);
    error_cnt++;
    $display("unexpected at %0t: run hung", $time);
    end_of_test();
  end
endmodule
